// File: rtl/flash_factory_program_sequencer.v
// command sequencer for factory erase and program of a banked flash
// assumes an apb master; flash bus writes are apb writes to the cmd word
`timescale 1ns/1ps
`include "flash_factory_regs.vh"

module flash_factory_program_sequencer (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  // engine state
  output wire engineBusy
);

  // sequencer states
  localparam ST_IDLE = 3'd0;
  localparam ST_ERS = 3'd1;
  localparam ST_PAGE = 3'd2;
  localparam ST_EFPC = 3'd3;
  localparam ST_EFPP = 3'd4;
  localparam ST_EFPV = 3'd5;
  localparam ST_WAIT = 3'd6;

  // per-bank read modes
  localparam MD_ARRAY = 2'd0;
  localparam MD_STATUS = 2'd1;
  localparam MD_ID = 2'd2;

  localparam [31:0] PROG_CYC32 = `PROG_CYC;
  localparam [31:0] ERASE_CYC32 = `ERASE_CYC;

  //////////////////////////////////////////////////////////////////////
  // reset release through two flops
  reg [1:0] rstSync_reg;
  wire rstN;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rstSync_reg <= 2'b00;
    else
      rstSync_reg <= {rstSync_reg[0], 1'b1};
  end

  assign rstN = rstSync_reg[1];

  //////////////////////////////////////////////////////////////////////
  // storage and control state
  reg [15:0] mem [0:31];
  reg [2:0] state_reg;
  reg opBank_reg;
  reg [2:0] pgNeed_reg;
  reg [2:0] pgCnt_reg;
  reg [4:0] pgAddr_reg [0:3];
  reg [15:0] pgData_reg [0:3];
  reg engBusy_reg;
  reg engErase_reg;
  reg [7:0] engCnt_reg;
  reg efpFirst_reg;
  reg [4:0] efpStart_reg;
  reg [4:0] efpPtr_reg;
  reg prFail_reg;
  reg erFail_reg;
  reg [3:0] mode_reg;
  reg [3:0] lock_reg;
  reg [4:0] rdAddr_reg;
  reg [31:0] prdata_reg;
  integer i;
  integer k;

  //////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, data latched in the setup cycle
  wire setupRd = psel & ~penable & ~pwrite;
  wire access = psel & penable;
  wire mapped = (paddr == `OFS_CMD) | (paddr == `OFS_RADDR) |
    (paddr == `OFS_RDATA) | (paddr == `OFS_STATUS) |
    (paddr == `OFS_LOCK) | (paddr == `OFS_SRCLR);
  wire cmdWr = access & pwrite & (paddr == `OFS_CMD);
  wire raddrWr = access & pwrite & (paddr == `OFS_RADDR);
  wire lockWr = access & pwrite & (paddr == `OFS_LOCK);
  wire clrWr = access & pwrite & (paddr == `OFS_SRCLR);

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_reg;
  assign engineBusy = engBusy_reg;

  // fields of a flash bus write
  wire [4:0] wA = pwdata[`CMD_ADDR_HI:`CMD_ADDR_LO];
  wire [15:0] wD = pwdata[15:0];
  wire [7:0] wC = pwdata[7:0];
  wire isReadCmd = (wC == `CODE_RD_ARRAY) | (wC == `CODE_RD_STATUS) |
    (wC == `CODE_RD_SIG) | (wC == `CODE_RD_QUERY);
  wire engDone = engBusy_reg & (engCnt_reg == 8'h01);

  // streamed target: start address again means auto-increment
  wire outBlk = wA[4:3] != efpStart_reg[4:3];
  wire [4:0] efpTgt = (wA == efpStart_reg) ? efpPtr_reg : wA;
  wire [15:0] tgtWord = mem[efpTgt];
  wire [4:0] nextPtr = {efpTgt[4:3], efpTgt[2:0] + 3'd1};

  //////////////////////////////////////////////////////////////////////
  // status byte
  wire sr7 = ~engBusy_reg & (state_reg != ST_EFPP) &
    (state_reg != ST_EFPV) & (state_reg != ST_WAIT);
  reg [7:0] statusByte;

  always @*
  begin
    statusByte = 8'h00;
    statusByte[`BIT_ENGINE_READY] = sr7;
    statusByte[`BIT_ERASE_FAIL] = erFail_reg;
    statusByte[`BIT_PROGRAM_FAIL] = prFail_reg;
    statusByte[`BIT_WRITE_READY] = engBusy_reg;
  end

  //////////////////////////////////////////////////////////////////////
  // flash read through the read address
  wire rdBank = rdAddr_reg[4];
  wire [1:0] rdMode = rdBank ? mode_reg[3:2] : mode_reg[1:0];
  wire forced = ((state_reg == ST_WAIT) | (state_reg == ST_EFPP) |
    (state_reg == ST_EFPV)) & (rdBank == opBank_reg);
  reg [15:0] rdWord;

  always @*
  begin
    if (forced | (rdMode == MD_STATUS))
      rdWord = {8'h00, statusByte};
    else if (rdMode == MD_ID)
      rdWord = `ID_CODE;
    else
      rdWord = mem[rdAddr_reg];
  end

  // read data register
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      prdata_reg <= 32'h00000000;
    else if (setupRd)
    begin
      case (paddr)
        `OFS_RADDR: prdata_reg <= {27'h0000000, rdAddr_reg};
        `OFS_RDATA: prdata_reg <= {16'h0000, rdWord};
        `OFS_STATUS: prdata_reg <= {21'h000000, state_reg, statusByte};
        `OFS_LOCK: prdata_reg <= {28'h0000000, lock_reg};
        default: prdata_reg <= 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // engine applies the work when its count runs out
  always @(posedge clk)
  begin
    if (engDone)
    begin
      for (i = 0; i < 32; i = i + 1)
      begin
        if (engErase_reg)
        begin
          if ((i[4] == opBank_reg) && !lock_reg[i[4:3]])
            mem[i] <= `DATA_ALL_ONES;
        end
        else
        begin
          for (k = 0; k < 4; k = k + 1)
          begin
            if ((k[2:0] < pgCnt_reg) && (pgAddr_reg[k] == i[4:0]))
              mem[i] <= mem[i] & pgData_reg[k];
          end
        end
      end
    end
  end

  // start one word on the engine
  task startWord;
    input [4:0] a;
    input [15:0] d;
    begin
      pgAddr_reg[0] <= a;
      pgData_reg[0] <= d;
      pgCnt_reg <= 3'd1;
      engBusy_reg <= 1'b1;
      engErase_reg <= 1'b0;
      engCnt_reg <= PROG_CYC32[7:0];
    end
  endtask

  // set the read mode of one bank
  task setMode;
    input b;
    input [1:0] m;
    begin
      if (b)
        mode_reg[3:2] <= m;
      else
        mode_reg[1:0] <= m;
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  // command sequencer
  // reset abort
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_reg <= ST_IDLE;
      opBank_reg <= 1'b0;
      pgNeed_reg <= 3'd0;
      pgCnt_reg <= 3'd0;
      for (i = 0; i < 4; i = i + 1)
      begin
        pgAddr_reg[i] <= 5'h00;
        pgData_reg[i] <= 16'h0000;
      end
      engBusy_reg <= 1'b0;
      engErase_reg <= 1'b0;
      engCnt_reg <= 8'h00;
      efpFirst_reg <= 1'b0;
      efpStart_reg <= 5'h00;
      efpPtr_reg <= 5'h00;
      prFail_reg <= 1'b0;
      erFail_reg <= 1'b0;
      mode_reg <= 4'h0;
      lock_reg <= `LOCK_RST;
      rdAddr_reg <= `RADDR_RST;
    end
    else
    begin
      // engine countdown
      if (engBusy_reg)
        engCnt_reg <= engCnt_reg - 8'h01;
      if (engDone)
        engBusy_reg <= 1'b0;
      if ((state_reg == ST_WAIT) && engDone)
        state_reg <= ST_IDLE;

      if (raddrWr)
        rdAddr_reg <= pwdata[4:0];
      if (lockWr && sr7)
        lock_reg <= pwdata[3:0];
      // clear first so a later set in the same cycle wins
      if (clrWr)
      begin
        prFail_reg <= 1'b0;
        erFail_reg <= 1'b0;
      end

      if (cmdWr)
      begin
        case (state_reg)
          ST_IDLE:
          begin
            if (isReadCmd)
              setMode(wA[4], (wC == `CODE_RD_ARRAY) ? MD_ARRAY :
                (wC == `CODE_RD_STATUS) ? MD_STATUS : MD_ID);
            else if (wC == `CODE_CLR_STATUS)
            begin
              prFail_reg <= 1'b0;
              erFail_reg <= 1'b0;
            end
            else if (wC == `CODE_BANK_ERASE)
              state_reg <= ST_ERS;
            else if ((wC == `CODE_TWO_WORD) || (wC == `CODE_FOUR_WORD))
            begin
              state_reg <= ST_PAGE;
              pgCnt_reg <= 3'd0;
              pgNeed_reg <= (wC == `CODE_TWO_WORD) ? 3'd2 : 3'd4;
            end
            else if (wC == `CODE_STREAM)
              state_reg <= ST_EFPC;
          end
          ST_ERS:
          begin
            setMode(wA[4], MD_STATUS);
            state_reg <= ST_IDLE;
            if (wC == `CODE_CONFIRM)
            begin
              opBank_reg <= wA[4];
              if (!(wA[4] ? &lock_reg[3:2] : &lock_reg[1:0]))
              begin
                engBusy_reg <= 1'b1;
                engErase_reg <= 1'b1;
                engCnt_reg <= ERASE_CYC32[7:0];
                state_reg <= ST_WAIT;
              end
            end
            else
            begin
              erFail_reg <= 1'b1;
              prFail_reg <= 1'b1;
            end
          end
          ST_PAGE:
          begin
            pgAddr_reg[pgCnt_reg[1:0]] <= wA;
            pgData_reg[pgCnt_reg[1:0]] <= wD;
            pgCnt_reg <= pgCnt_reg + 3'd1;
            if ((pgCnt_reg + 3'd1) == pgNeed_reg)
            begin
              opBank_reg <= wA[4];
              setMode(wA[4], MD_STATUS);
              if (lock_reg[wA[4:3]])
              begin
                prFail_reg <= 1'b1;
                state_reg <= ST_IDLE;
              end
              else
              begin
                engBusy_reg <= 1'b1;
                engErase_reg <= 1'b0;
                engCnt_reg <= PROG_CYC32[7:0];
                state_reg <= ST_WAIT;
              end
            end
          end
          ST_EFPC:
          begin
            setMode(wA[4], MD_STATUS);
            opBank_reg <= wA[4];
            if (wC != `CODE_CONFIRM)
            begin
              erFail_reg <= 1'b1;
              prFail_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
            else if (lock_reg[wA[4:3]])
            begin
              prFail_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
            else
            begin
              efpFirst_reg <= 1'b1;
              state_reg <= ST_EFPP;
            end
          end
          ST_EFPP:
          begin
            if (!engBusy_reg)
            begin
              if (efpFirst_reg)
              begin
                efpFirst_reg <= 1'b0;
                efpStart_reg <= wA;
                efpPtr_reg <= {wA[4:3], wA[2:0] + 3'd1};
                startWord(wA, wD);
              end
              else if (outBlk)
              begin
                if (wD == `DATA_ALL_ONES)
                begin
                  efpPtr_reg <= efpStart_reg;
                  state_reg <= ST_EFPV;
                end
              end
              else
              begin
                efpPtr_reg <= nextPtr;
                startWord(efpTgt, wD);
              end
            end
          end
          ST_EFPV:
          begin
            if (!engBusy_reg)
            begin
              if (outBlk)
              begin
                if (wD == `DATA_ALL_ONES)
                  state_reg <= ST_IDLE;
              end
              else
              begin
                efpPtr_reg <= nextPtr;
                if (tgtWord != wD)
                begin
                  if ((tgtWord & wD) != wD)
                    prFail_reg <= 1'b1;
                  else
                    startWord(efpTgt, wD);
                end
              end
            end
          end
          ST_WAIT:
          begin
            if (isReadCmd)
              setMode(wA[4], (wC == `CODE_RD_ARRAY) ? MD_ARRAY :
                (wC == `CODE_RD_STATUS) ? MD_STATUS : MD_ID);
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // flash_factory_program_sequencer

// File: rtl/flash_factory_regs.vh
// constants for the factory program sequencer
// assumes a 32-bit apb slave with byte addresses on paddr
`ifndef FLASH_FACTORY_REGS_VH
`define FLASH_FACTORY_REGS_VH

////////////////////////////////////////////////////////////////////////
// apb byte offsets
`define OFS_CMD 12'h000
`define OFS_RADDR 12'h004
`define OFS_RDATA 12'h008
`define OFS_STATUS 12'h00C
`define OFS_LOCK 12'h010
`define OFS_SRCLR 12'h014

// fields of the command word
`define CMD_ADDR_HI 20
`define CMD_ADDR_LO 16

// status byte bit positions
`define BIT_ENGINE_READY 7
`define BIT_ERASE_FAIL 5
`define BIT_PROGRAM_FAIL 4
`define BIT_WRITE_READY 0

// reset values
`define LOCK_RST 4'hF
`define RADDR_RST 5'h00

////////////////////////////////////////////////////////////////////////
// command codes
`define CODE_BANK_ERASE 8'h80
`define CODE_TWO_WORD 8'h35
`define CODE_FOUR_WORD 8'h56
`define CODE_STREAM 8'h30
`define CODE_CONFIRM 8'hD0
`define CODE_RD_ARRAY 8'hFF
`define CODE_RD_STATUS 8'h70
`define CODE_RD_SIG 8'h90
`define CODE_RD_QUERY 8'h98
`define CODE_CLR_STATUS 8'h50
`define DATA_ALL_ONES 16'hFFFF

// signature word, value is arbitrary
`define ID_CODE 16'h5A5A

////////////////////////////////////////////////////////////////////////
// engine timing
`define CLK_NS 40
`define PROG_NS 320
`define ERASE_NS 1280
`define PROG_CYC ((`PROG_NS + `CLK_NS - 1) / `CLK_NS)
`define ERASE_CYC ((`ERASE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// File: test/apb_host.sv
// apb master standing in for the host of the flash
// assumes a free-running clk; transfers are requested by task call
`timescale 1ns/1ps
module apb_host (
  // clock
  input wire clk,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // answer
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // wait overrun
  output logic stuck
);
  // bus idle at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stuck = 1'b0;
  end
  // setup cycle, then access held until pready is sampled high
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1)
      stuck <= 1'b1;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale data never shows after release
    pwdata <= ~d;
  endtask
endmodule // apb_host

// File: test/flash_factory_chk.sv
// port assertions for the factory program sequencer
// assumes one clk domain; bound below onto the design
`timescale 1ns/1ps
`include "flash_factory_regs.vh"
module flash_factory_chk (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // engine
  input wire engineBusy
);
  wire cmdWr;
  wire stRd;
  wire eraseGo;
  wire badConf;
  reg armReg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  // flash write and status read decode
  assign cmdWr = psel && penable && pwrite && (paddr == `OFS_CMD);
  assign stRd = psel && !penable && !pwrite && (paddr == `OFS_STATUS);
  assign eraseGo = cmdWr && armReg && !engineBusy && (pwdata[7:0] == `CODE_CONFIRM);
  assign badConf = cmdWr && armReg && !engineBusy && (pwdata[7:0] != `CODE_CONFIRM);
  // remembers that the last accepted write was an erase setup
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
      armReg <= 1'b0;
    else if (cmdWr && !engineBusy)
      armReg <= (pwdata[7:0] == `CODE_BANK_ERASE);
  // a program run: busy for eight cycles
  sequence busyRun8;
    engineBusy [*6] ##[1:4] !engineBusy;
  endsequence
  // an erase run: busy for thirty-two cycles
  sequence busyRun32;
    engineBusy ##30 engineBusy ##[1:4] !engineBusy;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  // engine start and run length, status bits and reset
  // an all-locked bank aborts without a run, so only a started erase is timed
  a_erase_timing: assert property ($rose(engineBusy) && $past(eraseGo) |-> busyRun32)
    else $error("erase run length wrong");
  a_prog_timing: assert property ($rose(engineBusy) && !$past(eraseGo) |-> busyRun8)
    else $error("program run length wrong");
  a_busy_cause: assert property ($rose(engineBusy) |-> $past(cmdWr))
    else $error("engine started without a flash write");
  a_busy_bounded: assert property ($rose(engineBusy) |-> ##[1:40] !engineBusy)
    else $error("engine stuck busy");
  a_status_busy: assert property (stRd |=> prdata[`BIT_WRITE_READY] == $past(engineBusy))
    else $error("status busy bit disagrees with engine");
  a_ready_excl: assert property (stRd |=> !(prdata[`BIT_ENGINE_READY] && prdata[0]))
    else $error("engine ready while busy");
  a_bad_confirm: assert property (badConf |=> !engineBusy [*3])
    else $error("erase ran without confirm");
  a_reset_idle: assert property (disable iff (1'b0) !arst_n |-> !engineBusy)
    else $error("engine busy in reset");
endmodule // flash_factory_chk
bind flash_factory_program_sequencer flash_factory_chk flash_factory_chk_i (.clk(clk),
  .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .engineBusy(engineBusy));

// File: test/tb_top.sv
// testbench for the factory program sequencer
// assumes the apb_host model and the bound checker
`timescale 1ns/1ps
`include "flash_factory_regs.vh"
module tb_top;
  logic clk;
  logic arst_n;
  wire psel, penable, pwrite, pready, pslverr, engineBusy, stuck;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  int errors;
  int total_checks;
  logic [31:0] rv;
  logic ev;
  flash_factory_program_sequencer flash_factory_program_sequencer_i (.clk(clk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .engineBusy(engineBusy));
  apb_host apb_host_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .stuck(stuck));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb_host_i.xfer(1'b1, a, d, rv, ev);
  endtask
  task rd(input logic [11:0] a);
    apb_host_i.xfer(1'b0, a, 32'h0, rv, ev);
  endtask
  // one flash bus write of address and data word
  task fw(input logic [4:0] a, input logic [15:0] d);
    wr(`OFS_CMD, {11'h000, a, d});
  endtask
  task checkFlash(input logic [4:0] a, input logic [31:0] exp);
    wr(`OFS_RADDR, {27'h0, a});
    rd(`OFS_RDATA);
    check("flash word", rv, exp);
  endtask
  // each block erased only a few times
  task eraseBank(input logic b);
    fw({b, 4'h0}, {8'h00, `CODE_BANK_ERASE});
    fw({b, 4'h0}, {8'h00, `CODE_CONFIRM});
  endtask
  // polls status until the word-busy bit clears
  task waitReady;
    int n;
    n = 0;
    rd(`OFS_STATUS);
    while (rv[0] !== 1'b0 && n < 100)
    begin
      rd(`OFS_STATUS);
      n++;
    end
    if (rv[0] !== 1'b0)
    begin
      errors++;
      report_and_stop;
    end
  endtask
  task streamPass;
    waitReady;
    fw(5'd16, 16'hA501);
    waitReady;
    fw(5'd16, 16'hA502);
    waitReady;
    fw(5'd20, 16'hA503);
    waitReady;
  endtask
  // a stuck transfer ends the run
  always @(posedge stuck)
  begin
    errors++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    errors = 0;
    total_checks = 0;
    arst_n = 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`OFS_LOCK);
    check("lock", rv, 32'hF);
    rd(`OFS_STATUS);
    check("status", rv, 32'h80);
    rd(12'h018);
    check("unmapped", {31'h0, ev}, 32'h1);
    wr(`OFS_LOCK, 32'h0);
    eraseBank(1'b0);
    @(negedge clk);
    check("busy", {31'h0, engineBusy}, 32'h1);
    checkFlash(5'd0, 32'h01);
    waitReady;
    checkFlash(5'd9, 32'h80);
    fw(5'd0, 16'h00FF);
    checkFlash(5'd9, 32'hFFFF);
    fw(5'd0, 16'h0080);
    fw(5'd0, 16'h0012);
    rd(`OFS_STATUS);
    check("status", rv, 32'hB0);
    wr(`OFS_SRCLR, 32'h0);
    $display("erase test done");
    fw(5'd0, 16'h0035);
    fw(5'd2, 16'h1234);
    fw(5'd3, 16'h5678);
    checkFlash(5'd2, 32'h01);
    waitReady;
    fw(5'd0, 16'h00FF);
    checkFlash(5'd2, 32'h1234);
    checkFlash(5'd3, 32'h5678);
    fw(5'd8, 16'h0056);
    for (int i = 0; i < 4; i++)
      fw(5'd8 + i[4:0], 16'hC100 + i[15:0]);
    fw(5'd8, 16'h0080);
    fw(5'd8, 16'h00D0);
    waitReady;
    check("status", rv, 32'h80);
    fw(5'd8, 16'h00FF);
    for (int i = 0; i < 4; i++)
      checkFlash(5'd8 + i[4:0], 32'hC100 + i);
    $display("page test done");
    wr(`OFS_LOCK, 32'h2);
    fw(5'd12, 16'h0035);
    fw(5'd12, 16'h1111);
    fw(5'd13, 16'h2222);
    waitReady;
    check("status", rv, 32'h90);
    wr(`OFS_SRCLR, 32'h0);
    fw(5'd12, 16'h00FF);
    checkFlash(5'd12, 32'hFFFF);
    wr(`OFS_LOCK, 32'h3);
    eraseBank(1'b0);
    waitReady;
    check("status", rv, 32'h80);
    fw(5'd0, 16'h00FF);
    checkFlash(5'd2, 32'h1234);
    $display("lock test done");
    wr(`OFS_LOCK, 32'h0);
    eraseBank(1'b1);
    waitReady;
    fw(5'd16, 16'h0030);
    fw(5'd16, 16'h00D0);
    rd(`OFS_STATUS);
    check("status", rv, 32'h400);
    streamPass;
    fw(5'd0, 16'h1234);
    rd(`OFS_STATUS);
    check("status", rv, 32'h400);
    fw(5'd0, 16'hFFFF);
    rd(`OFS_STATUS);
    check("status", rv, 32'h500);
    streamPass;
    fw(5'd0, 16'hFFFF);
    waitReady;
    check("status", rv, 32'h80);
    fw(5'd16, 16'h00FF);
    checkFlash(5'd16, 32'hA501);
    checkFlash(5'd17, 32'hA502);
    checkFlash(5'd20, 32'hA503);
    checkFlash(5'd18, 32'hFFFF);
    fw(5'd16, 16'h0090);
    checkFlash(5'd16, {16'h0000, `ID_CODE});
    // verify fixes a word that only loses ones, flags one that needs a one back
    fw(5'd24, 16'h0030);
    fw(5'd24, 16'h00D0);
    waitReady;
    fw(5'd24, 16'h00F0);
    waitReady;
    fw(5'd24, 16'h00F0);
    waitReady;
    fw(5'd0, 16'hFFFF);
    waitReady;
    fw(5'd24, 16'h0070);
    waitReady;
    fw(5'd24, 16'h00F1);
    waitReady;
    fw(5'd0, 16'hFFFF);
    waitReady;
    check("status", rv, 32'h90);
    wr(`OFS_SRCLR, 32'h0);
    fw(5'd24, 16'h00FF);
    checkFlash(5'd24, 32'h0070);
    checkFlash(5'd25, 32'h00F0);
    $display("stream test done");
    fw(5'd0, 16'h0035);
    fw(5'd4, 16'h3301);
    fw(5'd5, 16'h3302);
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    check("busy", {31'h0, engineBusy}, 32'h0);
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`OFS_STATUS);
    check("status", rv, 32'h80);
    rd(`OFS_LOCK);
    check("lock", rv, 32'hF);
    $display("reset test done");
    report_and_stop;
  end
endmodule // tb_top
